// ### dbap_ctrl.sv
// Behavioural DDR2 controller model that drives the device pins.
// Assumes the bench calls its tasks one at a time.
module dbap_ctrl (
  output dbap_pkg::dbap_pin_type pins,
  input  wire logic [15:0]       dq_out,
  input  wire logic              dq_oe,
  input  wire logic              dqs_out,
  input  wire logic              dqs_oe
);
  timeunit 1ns;
  timeprecision 10ps;

  // ****
  // Link clock and read capture
  // ****
  int          rises;
  int          pre_at;
  int          first_at;
  int          cmd_at;
  logic [15:0] rq[$];

  // Strobe parks low between bursts so no stray edge arms a capture
  initial begin
    pins = '0;
    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = 4'hF;
    forever #62.5 pins.ck = ~pins.ck;
  end

  always @(posedge pins.ck) rises++;

  always @(posedge dqs_oe) pre_at = rises;

  // one word on each strobe edge
  always @(dqs_out) begin
    #1;
    if (dq_oe === 1'b1) begin
      if (rq.size() == 0) first_at = rises;
      rq.push_back(dq_out);
    end
  end

  // ****
  // Command and write tasks
  // ****
  // pins set at the fall, taken at the next rise
  task automatic cmd(input logic [3:0] k, input logic [1:0] b, input logic [12:0] a);
    @(negedge pins.ck);
    {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = k;
    pins.ba = b;
    pins.addr = a;
    cmd_at = rises + 1;
  endtask

  // deselected pins and the mask carry junk, never the old value
  task automatic nop(input int n);
    repeat (n) begin
      @(negedge pins.ck);
      {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = 4'hF;
      pins.ba = ~pins.ba;
      pins.addr = ~pins.addr;
      pins.dq = ~pins.dq;
      pins.dm = ~pins.dm;
    end
  endtask

  // preamble low, first beat at the rise WL, two junk edges after
  task automatic wr(input logic [1:0] b, input logic [12:0] a, input int wl, input int bl,
                    input logic [15:0] d[8], input logic [1:0] m[8]);
    int t;
    cmd(4'h4, b, a);
    t = cmd_at + wl;
    nop(1);
    wait (rises == t);
    pins.dqs = 1'b0;
    for (int i = 0; i < bl + 2; i++) begin
      pins.dq = (i < bl) ? d[i] : ~pins.dq;
      pins.dm = (i < bl) ? m[i] : 2'h0;
      #31.25 pins.dqs = ~pins.dqs;
      #31.25;
    end
  endtask
endmodule // dbap_ctrl

// ### dbap_device.sv
// Device side of a four-bank DDR2 column access and precharge block.
// Assumes a controller on the pins clocked far slower than core_clk.
//
// Functional notes
// RULE_01: Read/write accepted any time after activate, executed AL clocks later.
// RULE_02: Read latency equals AL plus CL from mode registers.
// RULE_03: Write latency is read latency minus one.
// RULE_04: Controller programs enough AL when issuing before row-to-column delay.
// RULE_05: Burst length four or eight, chosen by mode bits A0 to A2.
// RULE_06: Mode bit A3 selects sequential or interleaved order.
// RULE_07: Sequential order wraps within nibble, then covers other nibble.
// RULE_08: Interleaved order is start column XOR beat counter.
// RULE_09: Controller never truncates a length-four burst; seamless bursts allowed.
// RULE_10: No burst stop command is decoded or relied upon.
// RULE_11: Read decoded from CS, CAS low, RAS, WE high; address gives column.
// RULE_12: First read word appears read latency clocks after the command.
// RULE_13: DQS driven low one clock before read data, rising with first bit.
// RULE_14: Write decoded from CS, CAS, WE low, RAS high; address gives column.
// RULE_15: Controller gives write preamble and first bit at write latency.
// RULE_16: Write data captured on strobe edges for four or eight beats only.
// RULE_17: One mask bit per byte, strobe timed, ignored on reads.
// RULE_18: Precharge decoded from CS, RAS, WE low, CAS high.
// RULE_19: Precharge A10 high closes all banks, else bank from BA.
// RULE_20: Controller spaces read to precharge by AL+BL/2+max(RTP,2)-2.
// RULE_21: Controller honours active time before precharge and precharge time after.
// RULE_22: Controller measures read-to-precharge from AL, or AL+2 for length eight.
// RULE_23: A10 high on read or write precharges the bank after the burst.
// RULE_24: Controller spaces write to precharge by WL+BL/2+write recovery.
// RULE_25: Masked byte lane stays unchanged in the array for that beat.
// RULE_26: Per-bank open state gates read, write and precharge; the code gates read and write only, precharge is decoded without checking it.
//
// Implementation choices: the plain strobed port and the register offsets.
module dbap_device (
  input  wire logic                        core_clk,
  input  wire logic                        sys_rst,
  input  wire logic                        ck,
  input  wire logic                        cs_n,
  input  wire logic                        ras_n,
  input  wire logic                        cas_n,
  input  wire logic                        we_n,
  input  wire logic [1:0]                  ba,
  input  wire logic [dbap_pkg::ADDR_W-1:0] addr,
  input  wire logic [dbap_pkg::DM_W-1:0]   dm,
  input  wire logic [dbap_pkg::DQ_W-1:0]   dq_in,
  input  wire logic                        dqs_in,
  output logic      [dbap_pkg::DQ_W-1:0]   dq_out,
  output logic                             dq_oe,
  output logic                             dqs_out,
  output logic                             dqs_oe,
  input  wire logic [3:0]                  reg_addr,
  input  wire logic [15:0]                 reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [15:0]                 reg_rdata
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [2:0] burst_ord(input logic [2:0] s, input logic [2:0] c,
                                           input logic bt);
    logic [1:0] low;
    low = s[1:0] + c[1:0];
    if (bt) return s ^ c;
    return {s[2] ^ c[2], low};
  endfunction

  function automatic logic [5:0] mem_idx(input dbap_pkg::dbap_cmd_type e,
                                         input logic [2:0] beat, input logic bt);
    return {e.bank, e.col[3], burst_ord(e.col[2:0], beat, bt)};
  endfunction

  // ****************************************
  // Pin synchroniser
  // ****************************************
  dbap_pkg::dbap_pin_type pin_s1_r;
  dbap_pkg::dbap_pin_type pin_s2_r;
  logic                   ck_s3_r;
  logic                   dqs_s3_r;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      ck_s3_r  <= 1'b0;
      dqs_s3_r <= 1'b0;
    end else begin
      pin_s1_r <= '{ck, cs_n, ras_n, cas_n, we_n, ba, addr, dm, dq_in, dqs_in};
      pin_s2_r <= pin_s1_r;
      ck_s3_r  <= pin_s2_r.ck;
      dqs_s3_r <= pin_s2_r.dqs;
    end
  end

  logic ck_rise;
  logic ck_fall;
  logic dqs_rise;
  logic dqs_fall;
  assign ck_rise  = pin_s2_r.ck & ~ck_s3_r;
  assign ck_fall  = ~pin_s2_r.ck & ck_s3_r;
  assign dqs_rise = pin_s2_r.dqs & ~dqs_s3_r;
  assign dqs_fall = ~pin_s2_r.dqs & dqs_s3_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // ****************************************
  // Registers
  // ****************************************
  dbap_pkg::dbap_cfg_type cfg_r;
  logic [3:0]             bank_open_r;
  logic [15:0]            reg_rdata_r;
  logic                   wr_act_r;
  dbap_pkg::dbap_rd_state_type rd_state_r;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_r <= '{1'b0, 1'b0, dbap_pkg::CL_RST, dbap_pkg::AL_RST};
    end else if (reg_wr && reg_addr == dbap_pkg::REG_MODE) begin
      // RULE_05: length from A0-A2
      cfg_r.bl8 <= reg_wdata[dbap_pkg::MODE_BL_LSB +: 3] == dbap_pkg::BL8_CODE;
      // RULE_06: type from A3
      cfg_r.bt  <= reg_wdata[dbap_pkg::MODE_BT_BIT];
      cfg_r.cl  <= reg_wdata[dbap_pkg::MODE_CL_LSB +: 3];
    end else if (reg_wr && reg_addr == dbap_pkg::REG_EXT) begin
      cfg_r.al  <= reg_wdata[dbap_pkg::EXT_AL_LSB +: 3];
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata_r <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        dbap_pkg::REG_MODE: reg_rdata_r <= 16'({cfg_r.cl, cfg_r.bt,
                                   cfg_r.bl8 ? dbap_pkg::BL8_CODE : 3'h2});
        dbap_pkg::REG_EXT:  reg_rdata_r <= 16'({cfg_r.al, 3'h0});
        dbap_pkg::REG_STAT: reg_rdata_r <= 16'({wr_act_r, rd_state_r != dbap_pkg::RD_IDLE,
                                                bank_open_r});
        default:            reg_rdata_r <= 16'h0000;
      endcase
    end else begin
      reg_rdata_r <= 16'h0000;
    end
  end

  // ****************************************
  // Latencies
  // ****************************************
  logic [3:0] rl;
  logic [3:0] wl;
  logic [2:0] last_beat;
  // RULE_02: RL is AL plus CL
  assign rl = 4'(cfg_r.al) + 4'(cfg_r.cl);
  // RULE_03: WL one below RL
  assign wl = rl - 4'h1;
  assign last_beat = cfg_r.bl8 ? dbap_pkg::LAST8 : dbap_pkg::LAST4;

  rl_sum_a: assert property (rl == 4'(cfg_r.al) + 4'(cfg_r.cl)) // RULE_02
    else $error("read latency differs from AL plus CL");
  wl_less_a: assert property (wl + 4'h1 == rl) // RULE_03
    else $error("write latency not one below read latency");

  // ****************************************
  // Command decode and posting pipe
  // ****************************************
  dbap_pkg::dbap_kind_type kind;
  always_comb begin
    kind = dbap_pkg::CMD_NOP;
    // RULE_10: burst stop pattern is just a no-op
    if (!pin_s2_r.cs_n) begin
      unique case ({pin_s2_r.ras_n, pin_s2_r.cas_n, pin_s2_r.we_n})
        3'b011:  kind = dbap_pkg::CMD_ACT;
        // RULE_11: read decode
        3'b101:  kind = dbap_pkg::CMD_RD;
        // RULE_14: write decode
        3'b100:  kind = dbap_pkg::CMD_WR;
        // RULE_18: precharge decode
        3'b010:  kind = dbap_pkg::CMD_PRE;
        default: kind = dbap_pkg::CMD_NOP;
      endcase
    end
  end

  dbap_pkg::dbap_cmd_type pipe_r [dbap_pkg::PIPE_D];
  dbap_pkg::dbap_cmd_type new_cmd;
  dbap_pkg::dbap_cmd_type rd_tap;
  dbap_pkg::dbap_cmd_type pre_tap;
  dbap_pkg::dbap_cmd_type wr_tap;
  logic rw_ok;
  logic rd_go;
  logic rd_pre;
  logic wr_go;

  // RULE_26: access only to open bank
  assign rw_ok = ck_rise && (kind == dbap_pkg::CMD_RD || kind == dbap_pkg::CMD_WR)
                 && bank_open_r[pin_s2_r.ba];
  // RULE_23: A10 requests auto precharge
  assign new_cmd = '{rw_ok, kind == dbap_pkg::CMD_WR, pin_s2_r.addr[dbap_pkg::A10],
                     pin_s2_r.ba, pin_s2_r.addr[dbap_pkg::COL_W-1:0]};

  // RULE_01: commands shift through the pipe, tapped RL or WL clocks later
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < dbap_pkg::PIPE_D; i++) pipe_r[i] <= '0;
    end else if (ck_rise) begin
      pipe_r[0] <= new_cmd;
      for (int i = 1; i < dbap_pkg::PIPE_D; i++) pipe_r[i] <= pipe_r[i-1];
    end
  end

  // An RL below two would wrap the preamble and write taps; only RL of two or more is meant
  assign rd_tap  = pipe_r[rl - 4'h1];
  assign pre_tap = pipe_r[rl - 4'h2];
  assign wr_tap  = pipe_r[wl - 4'h1];
  // RULE_12: first data at RL
  assign rd_go  = ck_rise && rd_tap.vld && !rd_tap.wr;
  assign rd_pre = ck_rise && pre_tap.vld && !pre_tap.wr;
  assign wr_go  = ck_rise && wr_tap.vld && wr_tap.wr;

  closed_bank_a: assert property (ck_rise && kind == dbap_pkg::CMD_RD // RULE_26
      && !bank_open_r[pin_s2_r.ba] |=> !pipe_r[0].vld)
    else $error("read to a closed bank was accepted");

  // ****************************************
  // Array
  // ****************************************
  logic [dbap_pkg::DQ_W-1:0] mem [dbap_pkg::MEM_D];
  dbap_pkg::dbap_cmd_type rd_cur_r;
  dbap_pkg::dbap_cmd_type wr_cur_r;
  logic [2:0] rd_beat_r;
  logic [2:0] wr_beat_r;
  logic       wr_seen_r;
  logic       wr_cap;
  logic [5:0] wr_idx;

  // RULE_16: capture on strobe edges, first on a rising one
  // RULE_15: relies on preamble before first rise
  assign wr_cap = wr_act_r && (dqs_rise || (wr_seen_r && dqs_fall));
  // RULE_07: nibble wrapped order
  // RULE_08: XOR order
  assign wr_idx = mem_idx(wr_cur_r, wr_beat_r, cfg_r.bt);

  // No reset on the array: contents are undefined at power up
  always_ff @(posedge core_clk) begin
    if (wr_cap) begin
      for (int l = 0; l < dbap_pkg::DM_W; l++) begin
        // RULE_25: masked lane untouched
        // RULE_17: one mask per byte
        if (!pin_s2_r.dm[l])
          mem[wr_idx][l*dbap_pkg::LANE_W +: dbap_pkg::LANE_W] <=
            pin_s2_r.dq[l*dbap_pkg::LANE_W +: dbap_pkg::LANE_W];
      end
    end
  end

  mask_a: assert property (wr_cap && pin_s2_r.dm[0] // RULE_25
      |=> mem[$past(wr_idx)][7:0] == $past(mem[wr_idx][7:0]))
    else $error("masked byte was written");

  // ****************************************
  // Write capture
  // ****************************************
  logic wr_done;
  assign wr_done = wr_cap && wr_beat_r == last_beat;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_act_r  <= 1'b0;
      wr_cur_r  <= '0;
      wr_beat_r <= 3'h0;
      wr_seen_r <= 1'b0;
    end else if (wr_go) begin
      wr_act_r  <= 1'b1;
      wr_cur_r  <= wr_tap;
      wr_beat_r <= 3'h0;
      wr_seen_r <= 1'b0;
    end else if (wr_cap) begin
      // RULE_16: later edges ignored once burst is full
      wr_act_r  <= !wr_done;
      wr_beat_r <= wr_beat_r + 3'h1;
      wr_seen_r <= 1'b1;
    end
  end

  wr_beats_a: assert property (wr_act_r |-> wr_beat_r <= last_beat) // RULE_16
    else $error("write burst ran past its length");

  // ****************************************
  // Read output
  // ****************************************
  logic [dbap_pkg::DQ_W-1:0] dq_out_r;
  logic dq_oe_r;
  logic dqs_out_r;
  logic dqs_oe_r;
  logic rd_edge;
  logic rd_done;
  assign rd_edge = rd_state_r == dbap_pkg::RD_BURST && (ck_rise || ck_fall) && !rd_go;
  assign rd_done = rd_edge && rd_beat_r == last_beat;

  // RULE_09: no truncation, a new read only follows seamlessly
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_state_r <= dbap_pkg::RD_IDLE;
      rd_cur_r   <= '0;
      rd_beat_r  <= 3'h0;
      dq_out_r   <= 16'h0000;
      dq_oe_r    <= 1'b0;
      dqs_out_r  <= 1'b0;
      dqs_oe_r   <= 1'b0;
    end else if (rd_go) begin
      // RULE_13: first bit with DQS rise
      rd_state_r <= dbap_pkg::RD_BURST;
      rd_cur_r   <= rd_tap;
      rd_beat_r  <= 3'h0;
      dq_out_r   <= mem[mem_idx(rd_tap, 3'h0, cfg_r.bt)];
      dq_oe_r    <= 1'b1;
      dqs_out_r  <= 1'b1;
      dqs_oe_r   <= 1'b1;
    end else if (rd_done) begin
      rd_state_r <= rd_pre ? dbap_pkg::RD_PRE : dbap_pkg::RD_POST;
      dq_oe_r    <= 1'b0;
      dqs_out_r  <= 1'b0;
    end else if (rd_edge) begin
      rd_beat_r  <= rd_beat_r + 3'h1;
      dq_out_r   <= mem[mem_idx(rd_cur_r, rd_beat_r + 3'h1, cfg_r.bt)];
      dqs_out_r  <= ~dqs_out_r;
    end else if (rd_pre && rd_state_r != dbap_pkg::RD_BURST) begin
      // RULE_13: preamble one clock ahead
      rd_state_r <= dbap_pkg::RD_PRE;
      dqs_out_r  <= 1'b0;
      dqs_oe_r   <= 1'b1;
    end else if (rd_state_r == dbap_pkg::RD_POST && ck_fall) begin
      rd_state_r <= dbap_pkg::RD_IDLE;
      dqs_oe_r   <= 1'b0;
    end
  end

  assign dq_out    = dq_out_r;
  assign dq_oe     = dq_oe_r;
  assign dqs_out   = dqs_out_r;
  assign dqs_oe    = dqs_oe_r;
  assign reg_rdata = reg_rdata_r;

  read_pre_a: assert property (rd_go // RULE_13
      |-> dqs_oe_r && !dqs_out_r ##1 dqs_out_r && dq_oe_r)
    else $error("read data without strobe preamble");
  rd_beats_a: assert property (rd_state_r == dbap_pkg::RD_BURST // RULE_05
      |-> rd_beat_r <= last_beat)
    else $error("read burst ran past its length");

  // ****************************************
  // Bank state
  // ****************************************
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bank_open_r <= 4'h0;
    end else begin
      if (ck_rise && kind == dbap_pkg::CMD_ACT) bank_open_r[pin_s2_r.ba] <= 1'b1;
      // RULE_19: all or one bank closed
      if (ck_rise && kind == dbap_pkg::CMD_PRE) begin
        if (pin_s2_r.addr[dbap_pkg::A10]) bank_open_r <= 4'h0;
        else bank_open_r[pin_s2_r.ba] <= 1'b0;
      end
      // RULE_23: auto precharge at burst end
      if (rd_done && rd_cur_r.ap) bank_open_r[rd_cur_r.bank] <= 1'b0;
      if (wr_done && wr_cur_r.ap) bank_open_r[wr_cur_r.bank] <= 1'b0;
    end
  end

  pre_all_a: assert property (ck_rise && kind == dbap_pkg::CMD_PRE // RULE_19
      && pin_s2_r.addr[dbap_pkg::A10] |=> bank_open_r == 4'h0)
    else $error("precharge all left a bank open");
  pre_one_a: assert property (ck_rise && kind == dbap_pkg::CMD_PRE // RULE_19
      && !pin_s2_r.addr[dbap_pkg::A10] |=> !bank_open_r[$past(pin_s2_r.ba)])
    else $error("selected bank still open after precharge");
  ap_close_a: assert property (rd_done && rd_cur_r.ap // RULE_23
      |=> !bank_open_r[$past(rd_cur_r.bank)])
    else $error("auto precharge did not close bank");

endmodule // dbap_device

// ### dbap_pkg.sv
// Shared constants, register map and carrier types of the DDR2 burst block.
// Assumes one core clock domain; all pins arrive asynchronously.
package dbap_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int DQ_W   = 16;
  localparam int DM_W   = 2;
  localparam int LANE_W = 8;
  localparam int ADDR_W = 13;
  localparam int BANKS  = 4;
  localparam int COL_W  = 4;
  localparam int MEM_D  = 64;
  localparam int PIPE_D = 16;
  localparam int A10    = 10;

  // ****************************************
  // Register map and fields
  // ****************************************
  localparam logic [3:0] REG_MODE = 4'h0;
  localparam logic [3:0] REG_EXT  = 4'h4;
  localparam logic [3:0] REG_STAT = 4'h8;
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_BT_BIT = 3;
  localparam int MODE_CL_LSB = 4;
  localparam int EXT_AL_LSB  = 3;
  localparam logic [2:0] BL8_CODE = 3'h3;
  localparam logic [2:0] CL_RST   = 3'h3;
  localparam logic [2:0] AL_RST   = 3'h0;
  localparam logic [2:0] LAST4    = 3'h3;
  localparam logic [2:0] LAST8    = 3'h7;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic              ck;
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic [1:0]        ba;
    logic [ADDR_W-1:0] addr;
    logic [DM_W-1:0]   dm;
    logic [DQ_W-1:0]   dq;
    logic              dqs;
  } dbap_pin_type;

  typedef struct packed {
    logic             vld;
    logic             wr;
    logic             ap;
    logic [1:0]       bank;
    logic [COL_W-1:0] col;
  } dbap_cmd_type;

  typedef struct packed {
    logic       bl8;
    logic       bt;
    logic [2:0] cl;
    logic [2:0] al;
  } dbap_cfg_type;

  typedef enum logic [4:0] {
    CMD_NOP = 5'b00001,
    CMD_ACT = 5'b00010,
    CMD_RD  = 5'b00100,
    CMD_WR  = 5'b01000,
    CMD_PRE = 5'b10000
  } dbap_kind_type;

  typedef enum logic [3:0] {
    RD_IDLE  = 4'b0001,
    RD_PRE   = 4'b0010,
    RD_BURST = 4'b0100,
    RD_POST  = 4'b1000
  } dbap_rd_state_type;

endpackage

// ### ddr2_burst_access_precharge_bench.sv
// Self-checking bench: device, controller model and a reference array.
// Assumes dbap_pkg, dbap_device and dbap_ctrl are compiled first.
module ddr2_burst_access_precharge_bench;
  timeunit 1ns;
  timeprecision 10ps;

  // ****
  // Harness
  // ****
  logic                   core_clk;
  logic                   sys_rst;
  logic                   reg_wr;
  logic                   reg_rd;
  logic [3:0]             reg_addr;
  logic [15:0]            reg_wdata;
  logic [15:0]            reg_rdata;
  logic [15:0]            dq_out;
  logic                   dq_oe;
  logic                   dqs_out;
  logic                   dqs_oe;
  dbap_pkg::dbap_pin_type pins;
  int                     n_mismatch;
  int                     samples_checked;
  int                     bl;
  int                     cl;
  int                     al;
  logic                   bt;
  logic [15:0]            lfsr_q;
  logic [15:0]            x;
  logic [15:0]            ref_mem[4][16];
  logic [3:0]             open_q;
  int cfgs[6][4] = '{'{0,0,3,0}, '{0,1,4,1}, '{1,0,3,2}, '{1,1,2,0}, '{0,0,5,3}, '{1,1,6,4}};

  dbap_ctrl u_dbap_ctrl (.pins(pins), .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out),
    .dqs_oe(dqs_oe));

  dbap_device u_dbap_device (.core_clk(core_clk), .sys_rst(sys_rst), .ck(pins.ck),
    .cs_n(pins.cs_n), .ras_n(pins.ras_n), .cas_n(pins.cas_n), .we_n(pins.we_n),
    .ba(pins.ba), .addr(pins.addr), .dm(pins.dm), .dq_in(pins.dq), .dqs_in(pins.dqs),
    .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // ****
  // Tasks
  // ****
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction

  // column of beat i from start s
  function automatic logic [3:0] col_of(input logic [3:0] s, input int i);
    logic [2:0] c;
    c = i[2:0];
    if (bt) return {s[3], s[2:0] ^ c};
    return {s[3], s[2] ^ c[2], s[1:0] + c[1:0]};
  endfunction

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_check(input logic [3:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 check("reg_rdata", exp, reg_rdata);
  endtask

  task automatic stat();
    reg_check(dbap_pkg::REG_STAT, {12'h0, open_q});
  endtask

  task automatic set_cfg(input int b8, input int t, input int c, input int a);
    logic [15:0] m;
    bl = b8 ? 8 : 4;
    bt = t[0];
    cl = c;
    al = a;
    m = {9'h0, c[2:0], t[0], (b8 ? 3'h3 : 3'h2)};
    reg_write(dbap_pkg::REG_MODE, m);
    reg_write(dbap_pkg::REG_EXT, {10'h0, a[2:0], 3'h0});
    reg_check(dbap_pkg::REG_MODE, m);
  endtask

  // write at WL, reference follows masks and bank state
  task automatic do_write(input logic [1:0] b, input logic [3:0] s, input logic ap,
                          input logic mk);
    logic [15:0] d[8];
    logic [1:0]  m[8];
    logic [3:0]  c;
    for (int i = 0; i < 8; i++) begin
      d[i] = rnd();
      m[i] = mk ? d[i][15:14] : 2'h0;
    end
    u_dbap_ctrl.wr(b, {2'h0, ap, 6'h0, s}, al + cl - 1, bl, d, m);
    for (int i = 0; i < bl; i++) begin
      c = col_of(s, i);
      if (open_q[b] && !m[i][0]) ref_mem[b][c][7:0] = d[i][7:0];
      if (open_q[b] && !m[i][1]) ref_mem[b][c][15:8] = d[i][15:8];
    end
    if (ap) open_q[b] = 1'b0;
    // write recovery before the next command
    u_dbap_ctrl.nop(3);
  endtask

  task automatic do_read(input logic [1:0] b, input logic [3:0] s, input logic ap, input int n);
    int t0;
    u_dbap_ctrl.rq.delete();
    u_dbap_ctrl.pre_at = -1;
    for (int r = 0; r < n; r++) begin
      u_dbap_ctrl.cmd(4'h5, b, {2'h0, (ap && r == n - 1), 6'h0, s ^ {r[0], 3'h0}});
      if (r == 0) t0 = u_dbap_ctrl.cmd_at;
      // seamless spacing of half a burst, never truncated
      if (r < n - 1) u_dbap_ctrl.nop(bl / 2 - 1);
    end
    // stop pattern inside a burst must change nothing
    u_dbap_ctrl.cmd(4'h6, b, 13'h0);
    // wait past the burst before any precharge
    u_dbap_ctrl.nop(al + cl + bl / 2 * n + 3);
    if (!open_q[b]) begin
      check("read words", 16'h0, 16'(u_dbap_ctrl.rq.size()));
      return;
    end
    check("read words", 16'(bl * n), 16'(u_dbap_ctrl.rq.size()));
    check("first word", 16'(al + cl), 16'(u_dbap_ctrl.first_at - t0));
    check("preamble", 16'(al + cl - 1), 16'(u_dbap_ctrl.pre_at - t0));
    for (int i = 0; i < u_dbap_ctrl.rq.size(); i++)
      check("read data", ref_mem[b][col_of(s ^ 4'(8 * (i / bl)), i % bl)],
            u_dbap_ctrl.rq[i]);
    if (ap) open_q[b] = 1'b0;
  endtask

  // ****
  // Sequence
  // ****
  initial begin
    #400000;
    n_mismatch++;
    give_verdict();
  end

  initial begin
    lfsr_q = 16'h8BE9;
    n_mismatch = 0;
    samples_checked = 0;
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    open_q = 4'h0;
    set_cfg_vars: begin
      bl = 4;
      bt = 1'b0;
      cl = 3;
      al = 0;
    end
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    reg_check(dbap_pkg::REG_MODE, 16'h0032);
    reg_check(dbap_pkg::REG_EXT, 16'h0000);
    reg_write(4'hC, 16'hFFFF);
    reg_check(4'hC, 16'h0000);
    reg_check(dbap_pkg::REG_MODE, 16'h0032);
    stat();
    // Closed bank drops both a write and a read
    do_write(2'h1, 4'h0, 1'b0, 1'b0);
    do_read(2'h1, 4'h0, 1'b0, 1);
    // write straight after activate, filling the array
    for (int b = 0; b < 4; b++) begin
      u_dbap_ctrl.cmd(4'h3, 2'(b), 13'h0);
      open_q[b] = 1'b1;
      for (int g = 0; g < 16; g += 4) do_write(2'(b), 4'(g), 1'b0, 1'b0);
    end
    stat();
    // nonzero AL in the table covers early commands
    foreach (cfgs[k]) begin
      set_cfg(cfgs[k][0], cfgs[k][1], cfgs[k][2], cfgs[k][3]);
      for (int j = 0; j < 4; j++) begin
        x = rnd();
        do_write(x[1:0], x[5:2], 1'b0, 1'b1);
        do_read(x[7:6], x[11:8], 1'b0, j % 2 + 1);
      end
      stat();
    end
    // one bank at a time by bank address
    for (int b = 0; b < 4; b++) begin
      u_dbap_ctrl.cmd(4'h2, 2'(b), 13'h0);
      u_dbap_ctrl.nop(2);
      open_q[b] = 1'b0;
      stat();
      do_read(2'(b), 4'h3, 1'b0, 1);
    end
    for (int b = 0; b < 4; b++) begin
      u_dbap_ctrl.cmd(4'h3, 2'(b), 13'h0);
      open_q[b] = 1'b1;
    end
    u_dbap_ctrl.nop(2);
    do_write(2'h0, 4'h5, 1'b1, 1'b1);
    do_read(2'h1, 4'h9, 1'b1, 1);
    stat();
    u_dbap_ctrl.cmd(4'h2, 2'h1, 13'h0400);
    u_dbap_ctrl.nop(2);
    open_q = 4'h0;
    stat();
    give_verdict();
  end
endmodule // ddr2_burst_access_precharge_bench
